/* core/sar_adc_pkg.sv */
// shared constants and carriers for the successive approximation converter sequencer
package sar_adc_pkg;

	// result, channel and counter geometry
	localparam int RES_BITS      = 10;
	localparam int CHAN_BITS     = 3;
	localparam int NUM_CHANNELS  = 6;
	localparam int DIV_CNT_BITS  = 7;
	localparam int RISE_CNT_BITS = 5;

	// conversion timing, in converter clock rises counted from the start rise
	localparam logic [RISE_CNT_BITS-1:0] INIT_EXTRA_RISES = 5'h0C;
	localparam logic [RISE_CNT_BITS-1:0] SAMPLE_RISE      = 5'h01;
	localparam logic [RISE_CNT_BITS-1:0] FIRST_BIT_RISE   = 5'h03;
	localparam logic [RISE_CNT_BITS-1:0] RESULT_RISE      = 5'h0D;

	// reset values, first trial bit and high byte padding
	localparam logic [RES_BITS-1:0]  RESULT_RESET = 10'h000;
	localparam logic [CHAN_BITS-1:0] CHAN_RESET   = 3'h0;
	localparam logic [2:0]           DIV_RESET    = 3'h0;
	localparam logic [RES_BITS-1:0]  TRIAL_MSB    = 10'h200;
	localparam logic [5:0]           HIGH_PAD     = 6'h00;

	// divider codes at and below this value divide by two
	localparam logic [2:0] DIV_MIN_CODE = 3'h1;

	// control write, one field per control bit and one for the three-bit divider code, most significant first
	typedef struct packed {
		logic       enable;
		logic       start;
		logic       free_run;
		logic       flag_clear;
		logic       irq_enable;
		logic [2:0] div_sel;
	} ctrl_t;

	// control and status readback
	typedef struct packed {
		logic       enable;
		logic       busy;
		logic       free_run;
		logic       done;
		logic       irq_enable;
		logic [2:0] div_sel;
	} status_t;

	// sequencer states
	typedef enum logic [1:0] {
		ST_IDLE,
		ST_CONV,
		ST_TAIL
	} seq_state_t;

	// prescaler mask: divisor minus one for a divider code
	function automatic logic [DIV_CNT_BITS-1:0] div_mask(input logic [2:0] code);
		logic [DIV_CNT_BITS:0] full;
		full = '0;
		if (code <= DIV_MIN_CODE) begin
			full = 8'h02;
		end else begin
			full = 8'h01 << code;
		end
		div_mask = DIV_CNT_BITS'(full - 8'h01);
	endfunction

endpackage

/* core/adc_prescaler.sv */
// enable-gated prescaler producing the converter clock and its edge ticks
`timescale 1ns/100ps
module adc_prescaler #(
	parameter int CNT_W = sar_adc_pkg::DIV_CNT_BITS
) (
	input  wire logic             clk,
	input  wire logic             rst,
	input  wire logic             enable_in,
	input  wire logic [2:0]       div_sel_in,
	output logic                  rise_tick_out,
	output logic                  fall_tick_out,
	output logic                  level_out
);
	import sar_adc_pkg::*;

	logic [CNT_W-1:0] cnt;
	logic [CNT_W-1:0] mask;
	logic [CNT_W-1:0] phase;

	// phase within the current converter period
	assign mask  = CNT_W'(div_mask(div_sel_in));
	assign phase = cnt & mask;

	// ticks mark the system cycle just before each converter clock edge
	assign rise_tick_out = enable_in && (phase == (mask >> 1));
	assign fall_tick_out = enable_in && (phase == mask);

	// counter runs while enabled, held at zero otherwise
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			cnt <= '0;
		end else if (!enable_in) begin
			cnt <= '0;
		end else begin
			cnt <= cnt + 1'b1;
		end
	end

	// divided clock level for the analog side
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			level_out <= 1'b0;
		end else if (!enable_in) begin
			level_out <= 1'b0;
		end else if (rise_tick_out) begin
			level_out <= 1'b1;
		end else if (fall_tick_out) begin
			level_out <= 1'b0;
		end
	end

endmodule

/* core/sar_adc_sequencer.sv */
// sequencer for a ten-bit successive approximation converter
`timescale 1ns/100ps
module sar_adc_sequencer (
	input  wire logic                               CORE_CLK_IN,
	input  wire logic                               RESET_IN,
	input  wire logic                               CTRL_WR_IN,
	input  wire sar_adc_pkg::ctrl_t                 CTRL_WDATA_IN,
	input  wire logic                               CHAN_WR_IN,
	input  wire logic [sar_adc_pkg::CHAN_BITS-1:0]  CHAN_WDATA_IN,
	input  wire logic                               RES_LOW_RD_IN,
	input  wire logic                               RES_HIGH_RD_IN,
	input  wire logic                               GLOBAL_IRQ_EN_IN,
	input  wire logic                               IRQ_ACK_IN,
	input  wire logic                               COMP_IN,
	output sar_adc_pkg::status_t                    STATUS_OUT,
	output logic [sar_adc_pkg::CHAN_BITS-1:0]       CHAN_SEL_OUT,
	output logic [7:0]                              RESULT_LOW_OUT,
	output logic [7:0]                              RESULT_HIGH_OUT,
	output logic [sar_adc_pkg::CHAN_BITS-1:0]       MUX_SEL_OUT,
	output logic                                    SAMPLE_OUT,
	output logic [sar_adc_pkg::RES_BITS-1:0]        DAC_OUT,
	output logic                                    CONV_CLK_OUT,
	output logic                                    IRQ_OUT
);
	import sar_adc_pkg::*;

	// configuration and control state
	logic                     enable;
	logic                     free_run;
	logic                     irq_enable;
	logic [2:0]               div_sel;
	logic                     start_bit;
	logic                     done_flag;
	logic                     init_pending;
	logic [CHAN_BITS-1:0]     chan_reg;

	// conversion state
	seq_state_t               state;
	logic [RISE_CNT_BITS-1:0] rise_cnt;
	logic                     first_conv;
	logic [RES_BITS-1:0]      trial_bit;
	logic [RES_BITS-1:0]      dac;
	logic [RES_BITS-1:0]      result;
	logic                     locked;
	logic                     sample;
	logic [CHAN_BITS-1:0]     mux_sel;
	logic                     irq;

	// derived terms
	logic                     next_enable;
	logic                     next_irq_enable;
	logic                     next_done;
	logic                     rise_tick;
	logic                     fall_tick;
	logic                     conv_level;
	logic [RISE_CNT_BITS-1:0] offset;
	logic [RISE_CNT_BITS-1:0] last_rise;
	logic [RISE_CNT_BITS-1:0] sample_rise;
	logic [RISE_CNT_BITS-1:0] decide_from;
	logic                     in_conv;
	logic                     complete;
	logic                     launch;
	logic                     restart;
	logic                     start_write;
	logic                     flag_clear;
	logic [RES_BITS-1:0]      kept;

	// enable as it stands after this cycle's write
	assign next_enable     = CTRL_WR_IN ? CTRL_WDATA_IN.enable : enable;
	assign next_irq_enable = CTRL_WR_IN ? CTRL_WDATA_IN.irq_enable : irq_enable;

	// a start write counts only with the converter enabled, also when enabled together
	assign start_write = CTRL_WR_IN && CTRL_WDATA_IN.start && next_enable;
	assign flag_clear  = (CTRL_WR_IN && CTRL_WDATA_IN.flag_clear) || IRQ_ACK_IN;

	// converter clock from the enable-gated prescaler
	adc_prescaler #(
		.CNT_W         (DIV_CNT_BITS)
	) u_prescaler (
		.clk           (CORE_CLK_IN),
		.rst           (RESET_IN),
		.enable_in     (enable),
		.div_sel_in    (div_sel),
		.rise_tick_out (rise_tick),
		.fall_tick_out (fall_tick),
		.level_out     (conv_level)
	);

	// timing marks shift by the initialisation pass on the first conversion
	assign offset      = first_conv ? INIT_EXTRA_RISES : '0;
	assign sample_rise = offset + SAMPLE_RISE;
	assign decide_from = offset + FIRST_BIT_RISE - 5'h01;
	assign last_rise   = offset + RESULT_RISE - 5'h01;

	// conversion events on converter clock edges
	assign in_conv  = enable && (state == ST_CONV);
	assign complete = in_conv && rise_tick && (rise_cnt == last_rise);
	assign restart  = complete && free_run;

	// a new conversion starts from idle or after the single-shot tail
	always_comb begin
		launch = 1'b0;
		if (enable && rise_tick && start_bit) begin
			if (state == ST_IDLE) begin
				launch = 1'b1;
			end else if (state == ST_TAIL) begin
				launch = 1'b1;
			end
		end
	end

	// configuration bits written by software
	always_ff @(posedge CORE_CLK_IN or posedge RESET_IN) begin
		if (RESET_IN) begin
			enable     <= 1'b0;
			free_run   <= 1'b0;
			irq_enable <= 1'b0;
			div_sel    <= DIV_RESET;
		end else if (CTRL_WR_IN) begin
			enable     <= CTRL_WDATA_IN.enable;
			free_run   <= CTRL_WDATA_IN.free_run;
			irq_enable <= CTRL_WDATA_IN.irq_enable;
			div_sel    <= CTRL_WDATA_IN.div_sel;
		end
	end

	// start bit: set by a write of one, cleared when a single conversion ends
	always_ff @(posedge CORE_CLK_IN or posedge RESET_IN) begin
		if (RESET_IN) begin
			start_bit <= 1'b0;
		end else if (!next_enable) begin
			start_bit <= 1'b0;
		end else if (start_write) begin
			start_bit <= 1'b1;
		end else if (complete && !free_run) begin
			start_bit <= 1'b0;
		end
	end

	// initialisation pass owed after every enable
	always_ff @(posedge CORE_CLK_IN or posedge RESET_IN) begin
		if (RESET_IN) begin
			init_pending <= 1'b1;
		end else if (!enable) begin
			init_pending <= 1'b1;
		end else if (launch) begin
			init_pending <= 1'b0;
		end
	end

	// channel register, written at any time; only valid inputs accepted
	always_ff @(posedge CORE_CLK_IN or posedge RESET_IN) begin
		if (RESET_IN) begin
			chan_reg <= CHAN_RESET;
		end else if (CHAN_WR_IN && (CHAN_WDATA_IN < CHAN_BITS'(NUM_CHANNELS))) begin
			chan_reg <= CHAN_WDATA_IN;
		end
	end

	// applied channel changes only when a conversion begins
	always_ff @(posedge CORE_CLK_IN or posedge RESET_IN) begin
		if (RESET_IN) begin
			mux_sel <= CHAN_RESET;
		end else if (launch || restart) begin
			mux_sel <= chan_reg;
		end
	end

	// sequencer state and converter rise count
	always_ff @(posedge CORE_CLK_IN or posedge RESET_IN) begin
		if (RESET_IN) begin
			state      <= ST_IDLE;
			rise_cnt   <= '0;
			first_conv <= 1'b0;
		end else if (!enable) begin
			state      <= ST_IDLE;
			rise_cnt   <= '0;
			first_conv <= 1'b0;
		end else begin
			case (state)
				ST_IDLE: begin
					if (launch) begin
						state      <= ST_CONV;
						rise_cnt   <= '0;
						first_conv <= init_pending;
					end
				end
				ST_CONV: begin
					if (restart) begin
						rise_cnt   <= '0;
						first_conv <= 1'b0;
					end else if (complete) begin
						state      <= ST_TAIL;
					end else if (rise_tick) begin
						rise_cnt   <= rise_cnt + 5'h01;
					end
				end
				ST_TAIL: begin
					if (launch) begin
						state      <= ST_CONV;
						rise_cnt   <= '0;
						first_conv <= init_pending;
					end else if (rise_tick) begin
						state      <= ST_IDLE;
					end
				end
				default: begin
					state <= ST_IDLE;
				end
			endcase
		end
	end

	// sample-and-hold strobe on the falling edge half a cycle past the sample rise
	always_ff @(posedge CORE_CLK_IN or posedge RESET_IN) begin
		if (RESET_IN) begin
			sample <= 1'b0;
		end else begin
			sample <= in_conv && fall_tick && (rise_cnt == sample_rise);
		end
	end

	// trial bit kept or dropped on the comparator decision
	assign kept = COMP_IN ? dac : (dac & ~trial_bit);

	// successive approximation register, most significant bit first
	always_ff @(posedge CORE_CLK_IN or posedge RESET_IN) begin
		if (RESET_IN) begin
			dac       <= RESULT_RESET;
			trial_bit <= RESULT_RESET;
		end else if (!in_conv) begin
			trial_bit <= RESULT_RESET;
		end else if (fall_tick && (rise_cnt == sample_rise)) begin
			dac       <= TRIAL_MSB;
			trial_bit <= TRIAL_MSB;
		end else if (rise_tick && (trial_bit != '0) && (rise_cnt >= decide_from)) begin
			dac       <= kept | (trial_bit >> 1);
			trial_bit <= trial_bit >> 1;
		end
	end

	// result bytes updated on completion unless held by a partial read
	always_ff @(posedge CORE_CLK_IN or posedge RESET_IN) begin
		if (RESET_IN) begin
			result <= RESULT_RESET;
		end else if (complete && !locked && !RES_LOW_RD_IN) begin
			result <= dac;
		end
	end

	// low byte read locks, high byte read releases
	always_ff @(posedge CORE_CLK_IN or posedge RESET_IN) begin
		if (RESET_IN) begin
			locked <= 1'b0;
		end else if (RES_LOW_RD_IN) begin
			locked <= 1'b1;
		end else if (RES_HIGH_RD_IN) begin
			locked <= 1'b0;
		end
	end

	// done flag: completion wins over a clear in the same cycle
	always_comb begin
		next_done = done_flag;
		if (complete) begin
			next_done = 1'b1;
		end else if (flag_clear) begin
			next_done = 1'b0;
		end
	end

	always_ff @(posedge CORE_CLK_IN or posedge RESET_IN) begin
		if (RESET_IN) begin
			done_flag <= 1'b0;
		end else begin
			done_flag <= next_done;
		end
	end

	// interrupt request follows flag, local and global enables
	always_ff @(posedge CORE_CLK_IN or posedge RESET_IN) begin
		if (RESET_IN) begin
			irq <= 1'b0;
		end else begin
			irq <= next_done && next_irq_enable && GLOBAL_IRQ_EN_IN;
		end
	end

	// readback and analog-side outputs, all from flip-flops
	assign STATUS_OUT.enable     = enable;
	assign STATUS_OUT.busy       = start_bit;
	assign STATUS_OUT.free_run   = free_run;
	assign STATUS_OUT.done       = done_flag;
	assign STATUS_OUT.irq_enable = irq_enable;
	assign STATUS_OUT.div_sel    = div_sel;
	assign CHAN_SEL_OUT          = chan_reg;
	assign RESULT_LOW_OUT        = result[7:0];
	assign RESULT_HIGH_OUT       = {HIGH_PAD, result[RES_BITS-1:8]};
	assign MUX_SEL_OUT           = mux_sel;
	assign SAMPLE_OUT            = sample;
	assign DAC_OUT               = dac;
	assign CONV_CLK_OUT          = conv_level;
	assign IRQ_OUT               = irq;

endmodule

/* dv/sar_adc_properties.sv */
// assertion checker watching the converter sequencer ports
`timescale 1ns/100ps
module sar_adc_properties (
	input wire logic                 CORE_CLK_IN,
	input wire logic                 RESET_IN,
	input wire logic                 CTRL_WR_IN,
	input wire sar_adc_pkg::ctrl_t   CTRL_WDATA_IN,
	input wire logic                 RES_LOW_RD_IN,
	input wire logic                 RES_HIGH_RD_IN,
	input wire logic                 GLOBAL_IRQ_EN_IN,
	input wire sar_adc_pkg::status_t STATUS_OUT,
	input wire logic [7:0]           RESULT_LOW_OUT,
	input wire logic [7:0]           RESULT_HIGH_OUT,
	input wire logic                 SAMPLE_OUT,
	input wire logic                 CONV_CLK_OUT,
	input wire logic                 IRQ_OUT
);
	import sar_adc_pkg::*;

	logic locked;

	default clocking cb @(posedge CORE_CLK_IN);
	endclocking
	default disable iff (RESET_IN);

	// lock state following the byte reads
	always_ff @(posedge CORE_CLK_IN or posedge RESET_IN) begin
		if (RESET_IN) begin
			locked <= 1'b0;
		end else if (RES_LOW_RD_IN) begin
			locked <= 1'b1;
		end else if (RES_HIGH_RD_IN) begin
			locked <= 1'b0;
		end
	end

	// result bytes, done flag, start bit, prescaler and interrupt relations
	a_lock_holds_result: assert property (
		locked |-> $stable({RESULT_HIGH_OUT, RESULT_LOW_OUT}))
		else $error("result bytes changed while locked");
	a_done_on_write: assert property (
		$changed({RESULT_HIGH_OUT, RESULT_LOW_OUT}) |-> ##[0:1] STATUS_OUT.done)
		else $error("result written without done flag");
	a_busy_fall_done: assert property (
		$fell(STATUS_OUT.busy) && STATUS_OUT.enable |-> ##[0:1] STATUS_OUT.done)
		else $error("start bit cleared without completion");
	a_no_self_start: assert property (
		$rose(STATUS_OUT.busy) |-> $past(CTRL_WR_IN && CTRL_WDATA_IN.start))
		else $error("conversion began without a start write");
	a_disable_aborts: assert property (
		CTRL_WR_IN && !CTRL_WDATA_IN.enable |=> !STATUS_OUT.busy && !STATUS_OUT.enable)
		else $error("disable did not abort");
	a_sample_one_pulse: assert property (
		SAMPLE_OUT |-> STATUS_OUT.busy ##1 !SAMPLE_OUT)
		else $error("sample pulse outside conversion or too long");
	a_irq_gate: assert property (
		IRQ_OUT == (STATUS_OUT.done && STATUS_OUT.irq_enable && $past(GLOBAL_IRQ_EN_IN)))
		else $error("interrupt request mismatch");
	a_clk_held_off: assert property (
		!STATUS_OUT.enable [*2] |-> !CONV_CLK_OUT)
		else $error("converter clock runs while disabled");
	a_div_two_high: assert property (
		$rose(CONV_CLK_OUT) && STATUS_OUT.div_sel <= DIV_MIN_CODE && STATUS_OUT.enable
		&& $stable(STATUS_OUT.div_sel)
		|=> !CONV_CLK_OUT)
		else $error("divide by two high phase too long");
	a_div_four_high: assert property (
		$rose(CONV_CLK_OUT) && STATUS_OUT.div_sel == 3'h2 && STATUS_OUT.enable
		&& $stable(STATUS_OUT.div_sel)
		|-> CONV_CLK_OUT [*2] ##1 !CONV_CLK_OUT)
		else $error("divide by four high phase wrong");
endmodule

bind sar_adc_sequencer sar_adc_properties sar_adc_properties_inst (
	.CORE_CLK_IN      (CORE_CLK_IN),
	.RESET_IN         (RESET_IN),
	.CTRL_WR_IN       (CTRL_WR_IN),
	.CTRL_WDATA_IN    (CTRL_WDATA_IN),
	.RES_LOW_RD_IN    (RES_LOW_RD_IN),
	.RES_HIGH_RD_IN   (RES_HIGH_RD_IN),
	.GLOBAL_IRQ_EN_IN (GLOBAL_IRQ_EN_IN),
	.STATUS_OUT       (STATUS_OUT),
	.RESULT_LOW_OUT   (RESULT_LOW_OUT),
	.RESULT_HIGH_OUT  (RESULT_HIGH_OUT),
	.SAMPLE_OUT       (SAMPLE_OUT),
	.CONV_CLK_OUT     (CONV_CLK_OUT),
	.IRQ_OUT          (IRQ_OUT)
);

/* dv/sar_analog_model.sv */
// sample-and-hold and comparator model facing the sequencer
`timescale 1ns/100ps
module sar_analog_model (
	input  wire logic            clk_in,
	input  wire logic            sample_in,
	input  wire logic [2:0]      mux_sel_in,
	input  wire logic [9:0]      dac_in,
	input  wire logic [5:0][9:0] level_in,
	output logic                 comp_out
);
	logic [9:0] held = 10'h000;

	// capture the selected input on the sample pulse
	always_ff @(posedge clk_in) begin
		if (sample_in) begin
			held <= level_in[mux_sel_in];
		end
	end

	// keep the trial bit while the held input reaches it
	assign comp_out = (held >= dac_in);
endmodule

/* dv/sar_adc_sequencer_bench.sv */
// self-checking bench for the converter sequencer
`timescale 1ns/100ps
module sar_adc_sequencer_bench;
	import sar_adc_pkg::*;

	typedef struct {
		int          lo;
		int          hi;
		logic [15:0] res;
	} note_t;

	logic            clk;
	logic            rst;
	logic            ctrl_wr;
	ctrl_t           ctrl;
	logic            chan_wr;
	logic [2:0]      chan;
	logic            low_rd;
	logic            high_rd;
	logic            gie;
	logic            ack;
	logic            comp;
	status_t         status;
	logic [7:0]      res_lo;
	logic [7:0]      res_hi;
	logic [2:0]      mux;
	logic [2:0]      chan_rb;
	logic            sample;
	logic [9:0]      dac;
	logic            conv_clk;
	logic            irq;
	logic [5:0][9:0] lvl;
	note_t           notes[$];
	note_t           n;
	int              n_errors;
	int              n_compared;
	int              cnt;
	logic            prev_done;
	logic [15:0]     seed;
	logic [15:0]     last;
	logic            fr;
	logic            ie;
	logic [2:0]      dv;
	logic            alt;

	sar_adc_sequencer sar_adc_sequencer_inst (
		.CORE_CLK_IN(clk), .RESET_IN(rst), .CTRL_WR_IN(ctrl_wr), .CTRL_WDATA_IN(ctrl),
		.CHAN_WR_IN(chan_wr), .CHAN_WDATA_IN(chan), .RES_LOW_RD_IN(low_rd),
		.RES_HIGH_RD_IN(high_rd), .GLOBAL_IRQ_EN_IN(gie), .IRQ_ACK_IN(ack), .COMP_IN(comp),
		.STATUS_OUT(status), .CHAN_SEL_OUT(chan_rb), .RESULT_LOW_OUT(res_lo),
		.RESULT_HIGH_OUT(res_hi), .MUX_SEL_OUT(mux), .SAMPLE_OUT(sample), .DAC_OUT(dac),
		.CONV_CLK_OUT(conv_clk), .IRQ_OUT(irq));

	sar_analog_model sar_analog_model_inst (
		.clk_in(clk), .sample_in(sample), .mux_sel_in(mux), .dac_in(dac),
		.level_in(lvl), .comp_out(comp));

	function automatic logic [15:0] lfsr(input logic [15:0] x);
		lfsr = {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
	endfunction

	function automatic int dval(input logic [2:0] c);
		dval = (c <= 3'h1) ? 2 : (1 << c);
	endfunction

	task automatic print_verdict();
		$display("compared %0d mismatches %0d", n_compared, n_errors);
		if (n_errors == 0 && n_compared > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask

	task automatic bad(input logic [15:0] g, input logic [15:0] e);
		$display("ERROR at %0t: got %h expected %h", $time, g, e);
		n_errors++;
	endtask

	task automatic cmp_res(input logic [15:0] e, input logic [15:0] g);
		n_compared++;
		if (g !== e) begin
			bad(g, e);
		end
	endtask

	task automatic cmp_lat(input int lo, input int hi, input int g);
		n_compared++;
		if (g < lo || g > hi) begin
			bad(16'(g), 16'(lo));
		end
	endtask

	task automatic cyc(input int k);
		repeat (k) @(posedge clk);
		#1;
	endtask

	// one-cycle strobes: 0 low read, 1 high read, 2 vector taken, 3 channel write
	task automatic pulse(input int k);
		case (k)
			0: low_rd = 1'b1;
			1: high_rd = 1'b1;
			2: ack = 1'b1;
			default: chan_wr = 1'b1;
		endcase
		cyc(1);
		{low_rd, high_rd, ack, chan_wr} = 4'h0;
	endtask

	task automatic wr(input logic en, input logic st, input logic fc);
		ctrl = {en, st, fr, fc, ie, dv};
		ctrl_wr = 1'b1;
		cyc(1);
		ctrl_wr = 1'b0;
	endtask

	task automatic wait_done();
		int i;
		i = 0;
		while (status.done !== 1'b1 && i < 5000) begin
			cyc(1);
			i++;
		end
		if (i == 5000) begin
			bad(16'(status), 16'h0010);
			print_verdict();
		end
	endtask

	// clear the done flag, by vector and by writing one in turn
	task automatic clr();
		alt = ~alt;
		if (alt) begin
			pulse(2);
		end else begin
			wr(1'b1, 1'b0, 1'b1);
		end
		cyc(1);
	endtask

	// single conversion on channel c; e < 0 keeps the old result; mid < 8 rewrites channel
	task automatic conv(input logic [2:0] c, input int e, input int mul, input logic [3:0] mid);
		int d;
		d = dval(dv);
		chan = c;
		pulse(3);
		if (c < 3'h6) begin
			cmp_res(16'(c), 16'(chan_rb));
		end
		if (e >= 0) begin
			last = {6'h00, lvl[e]};
		end
		notes.push_back('{mul * d, mul * d + d + 4, last});
		wr(1'b1, 1'b1, 1'b0);
		if (mid < 4'h8) begin
			cyc(6);
			chan = mid[2:0];
			pulse(3);
		end
		wait_done();
		clr();
	endtask

	task automatic shuffle();
		for (int k = 0; k < 6; k++) begin
			seed = lfsr(seed);
			lvl[k] = seed[9:0];
		end
	endtask

	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end

	// watcher: interval counter, result and interval check on each completion
	always @(posedge clk) begin
		cnt++;
		if (ctrl_wr && ctrl.start && !status.busy && !status.done) begin
			cnt = 0;
		end
		if (status.done && !prev_done) begin
			if (notes.size() == 0) begin
				bad({res_hi, res_lo}, 16'h0000);
			end else begin
				n = notes.pop_front();
				cmp_res(n.res, {res_hi, res_lo});
				cmp_lat(n.lo, n.hi, cnt);
			end
			cnt = 0;
		end
		prev_done = status.done;
	end

	initial begin
		{ctrl_wr, chan_wr, low_rd, high_rd, ack} = 5'h00;
		{rst, gie, ie, fr, alt, prev_done} = 6'h38;
		{ctrl, chan, dv, last} = '0;
		{n_errors, n_compared, cnt} = '0;
		seed = 16'hD918;
		shuffle();
		repeat (12) @(posedge clk);
		#1;
		rst = 1'b0;
		cyc(1);
		conv(3'h2, 2, 25, 4'hF);
		$display("test first_conversion done");
		for (int c = 0; c < 8; c++) begin
			dv = c[2:0];
			shuffle();
			gie = seed[1];
			conv(3'(seed % 6), int'(seed % 6), 13, 4'hF);
		end
		$display("test divider_codes done");
		dv = 3'h1;
		conv(3'h1, 1, 13, 4'h3);
		conv(3'h6, 3, 13, 4'hF);
		$display("test channel_deferral done");
		pulse(0);
		conv(3'h4, -1, 13, 4'hF);
		pulse(1);
		conv(3'h4, 4, 13, 4'hF);
		$display("test result_lock done");
		dv = 3'h3;
		notes.push_back('{104, 116, last});
		wr(1'b1, 1'b1, 1'b0);
		wait_done();
		notes.push_back('{112, 112, last});
		wr(1'b1, 1'b1, 1'b0);
		clr();
		wait_done();
		clr();
		$display("test pending_start done");
		dv = 3'h2;
		fr = 1'b1;
		notes.push_back('{52, 60, last});
		notes.push_back('{52, 52, last});
		notes.push_back('{52, 52, last});
		wr(1'b1, 1'b1, 1'b0);
		repeat (3) begin
			wait_done();
			clr();
		end
		cyc(10);
		wr(1'b0, 1'b0, 1'b0);
		cyc(100);
		$display("test free_run_abort done");
		fr = 1'b0;
		dv = 3'h1;
		conv(3'h5, 5, 25, 4'hF);
		$display("test reenable done");
		cyc(20);
		if (notes.size() != 0) begin
			bad(16'(notes.size()), 16'h0000);
		end
		print_verdict();
	end
endmodule
